// File: design/rct_defs.svh
/*
 * constants for the repeating cycle timer: register offsets, field
 * positions, reset values, widths and timing figures.
 * assumes a 100 MHz system clock and byte addressed 32-bit registers.
 */
`ifndef RCT_DEFS_SVH
`define RCT_DEFS_SVH

// widths
`define RCT_TW 20
`define RCT_CW 8
`define RCT_DIVW 27
`define RCT_DBW 21

// timing
`define RCT_CLK_HZ 100000000
`define RCT_TICK_S 1
`define RCT_TICK_CYC (`RCT_CLK_HZ * `RCT_TICK_S)
`define RCT_DB_MS 10
`define RCT_DB_CYC (`RCT_CLK_HZ / 1000 * `RCT_DB_MS)
`define RCT_QUAL_S 3

// register byte offsets
`define RCT_A_CTRL 8'h00
`define RCT_A_SET 8'h04
`define RCT_A_DLY 8'h08
`define RCT_A_TGT 8'h0C
`define RCT_A_STAT 8'h10
`define RCT_A_TIME 8'h14
`define RCT_A_DDISP 8'h18
`define RCT_A_ISTAT 8'h1C
`define RCT_A_IMASK 8'h20
`define RCT_A_CODE 8'h24
`define RCT_A_NCODE 8'h28

// control field positions and the mask of the key settings
`define RCT_C_FUNC 0
`define RCT_C_DOWN 1
`define RCT_C_PAUSE 2
`define RCT_C_OP1EN 3
`define RCT_C_OP2EN 4
`define RCT_C_LOCEN 5
`define RCT_C_REPEAT 6
`define RCT_CTRL_SAFE 7'h5A

// interrupt bits
`define RCT_I_CYCLE 0
`define RCT_I_DONE 1
`define RCT_I_REFUSE 2
`define RCT_I_FSAFE 3

// reset values
`define RCT_CTRL_RST 7'h07
`define RCT_SET_RST 20'h0_0000
`define RCT_DLY_RST 20'h0_0000
`define RCT_TGT_RST 8'h01
`define RCT_CODE_RST 16'h0000

`endif

// File: design/rct_pkg.sv
/*
 * types of the repeating cycle timer: sequencer states and the packed
 * state records of the timer and the contact debouncer.
 * assumes rct_defs.svh is on the include path.
 */
`include "rct_defs.svh"

package rct_pkg;

   // sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_READY = 6'b00_0001,
      ST_RUN = 6'b00_0010,
      ST_DELAY = 6'b00_0100,
      ST_PAUSE = 6'b00_1000,
      ST_DONE = 6'b01_0000,
      ST_HALT = 6'b10_0000
   } rct_state_t;

   // debouncer state
   typedef struct packed {
      logic s1;
      logic s2;
      logic stable;
      logic rise;
      logic [`RCT_DBW-1:0] cnt;
   } rct_db_t;

   // timer state
   typedef struct packed {
      rct_state_t st;
      logic resume_dly;
      logic [`RCT_DIVW-1:0] div;
      logic [`RCT_TW-1:0] run_el;
      logic [`RCT_TW-1:0] dly_el;
      logic [`RCT_CW-1:0] cyc;
      logic [1:0] qual;
      logic qual_done;
      logic [6:0] ctrl;
      logic [`RCT_TW-1:0] set_time;
      logic [`RCT_TW-1:0] delay;
      logic [`RCT_CW-1:0] target;
      logic [3:0] istat;
      logic [3:0] imask;
      logic [15:0] code;
      logic unlocked;
      logic [31:0] rdata;
      logic op1;
      logic op2;
      logic rst_ind;
      logic irq;
      logic [`RCT_TW-1:0] tdisp;
      logic [`RCT_TW-1:0] ddisp;
   } rct_top_t;

endpackage : rct_pkg

// File: design/rct_debounce.sv
/*
 * contact debouncer: two-stage synchroniser, then a level that changes
 * only after the input has held steady for DB_CYC clocks, plus a
 * one-cycle pulse on each accepted closure.
 * assumes a raw contact level, active high while closed.
 */
`include "rct_defs.svh"

module rct_debounce #(
   parameter int DB_CYC = `RCT_DB_CYC
) (
   input wire logic i_sys_clk, // system clock
   input wire logic i_rst, // synchronous reset, high
   input wire logic i_raw, // raw contact level
   output logic o_level, // debounced level
   output logic o_rise // pulse on accepted closure
);
   rct_pkg::rct_db_t cur_ff;
   rct_pkg::rct_db_t nxt_db;
   localparam logic [`RCT_DBW-1:0] LIM = `RCT_DBW'(DB_CYC - 1);

   // synchronise, then accept a change once it has stood long enough
   always_comb begin
      nxt_db = cur_ff;
      nxt_db.s1 = i_raw;
      nxt_db.s2 = cur_ff.s1;
      nxt_db.rise = 1'b0;
      if (cur_ff.s2 == cur_ff.stable) begin
         nxt_db.cnt = '0;
      end else if (cur_ff.cnt >= LIM) begin
         nxt_db.cnt = '0;
         nxt_db.stable = cur_ff.s2; // RULE16
         nxt_db.rise = cur_ff.s2; // RULE16
      end else begin
         nxt_db.cnt = cur_ff.cnt + 1'b1;
      end
   end

   // state register
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_db;
      end
   end

   assign o_level = cur_ff.stable;
   assign o_rise = cur_ff.rise;
endmodule : rct_debounce

// File: design/rct_timer.sv
/*
 * repeating cycle timer: times an on period, waits a restart delay and
 * repeats up to a target count, then flags completion until a qualified
 * clear. holds its settings in a small register file with a security
 * code gate and a masked sticky interrupt.
 * assumes contact inputs are raw levels and the bus master follows the
 * one-cycle strobe protocol with read data one cycle later.
 */
// The address map and the strobed register port were left to the implementer.
`include "rct_defs.svh"

// Operation
// RULE1 - start closes output one, times set period
// RULE2 - period end opens output, counts restart delay
// RULE3 - delay end recloses, repeats until target count
// RULE4 - after last period, done closes output two
// RULE5 - done holds until clear held three seconds
// RULE6 - down mode decrements times, cycles count up
// RULE7 - pause mode: outputs off, resume on start
// RULE8 - start ignored until cleared; local clear gated
// RULE9 - zero set time refuses start
// RULE10 - each output needs its own enable
// RULE11 - settings locked until code matches stored code
// RULE12 - timer acts only in elapsed timing function
// RULE13 - stop pauses; start resumes same point
// RULE14 - key setting change forces fail-safe halt
// RULE15 - one second tick drives all counters
// RULE16 - contacts debounced and synchronised before use
module rct_timer #(
   parameter int TICK_CYC = `RCT_TICK_CYC,
   parameter int DB_CYC = `RCT_DB_CYC
) (
   input wire logic i_sys_clk, // system clock, 100 MHz
   input wire logic i_rst, // synchronous reset, high
   input wire logic i_start_contact, // raw start contact
   input wire logic i_stop_contact, // raw stop contact
   input wire logic i_clear_contact, // raw external clear contact
   input wire logic i_local_clear, // raw local button combination
   input wire logic i_power_restore, // pulse after power returns
   input wire logic [7:0] i_addr, // register byte address
   input wire logic [31:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [31:0] o_rdata, // read data, cycle after strobe
   output logic o_primary_ctl, // primary control output
   output logic o_secondary_ctl, // secondary control output
   output logic o_clear_ind, // clear annunciator
   output logic o_irq, // interrupt, level
   output logic [`RCT_TW-1:0] o_time_disp, // on period display
   output logic [`RCT_TW-1:0] o_delay_disp, // restart delay display
   output logic [`RCT_CW-1:0] o_cycle_cnt // completed cycles
);
   localparam logic [`RCT_DIVW-1:0] TICK_LIM =
      `RCT_DIVW'(TICK_CYC - 1);
   // full ticks counted after the first, so the hold is never short
   localparam logic [1:0] QUAL_LIM = 2'(`RCT_QUAL_S);

   rct_pkg::rct_top_t cur_ff;
   rct_pkg::rct_top_t nxt_t;
   logic start_lvl, start_p, stop_lvl, stop_p;
   logic clr_lvl, loc_lvl;
   logic tick, timer_fn, down, clr_held, do_clear;
   logic [`RCT_CW-1:0] cyc_inc, tgt_eff;
   logic [6:0] wctrl;

   // debounced contacts
   rct_debounce #(.DB_CYC(DB_CYC)) u_db_start (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_raw(i_start_contact),
      .o_level(start_lvl),
      .o_rise(start_p)
   );
   rct_debounce #(.DB_CYC(DB_CYC)) u_db_stop (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_raw(i_stop_contact),
      .o_level(stop_lvl),
      .o_rise(stop_p)
   );
   rct_debounce #(.DB_CYC(DB_CYC)) u_db_clear (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_raw(i_clear_contact),
      .o_level(clr_lvl),
      .o_rise()
   );
   rct_debounce #(.DB_CYC(DB_CYC)) u_db_local (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_raw(i_local_clear),
      .o_level(loc_lvl),
      .o_rise()
   );

   // decoded helpers
   assign tick = (cur_ff.div == TICK_LIM);
   assign timer_fn = cur_ff.ctrl[`RCT_C_FUNC];
   assign down = cur_ff.ctrl[`RCT_C_DOWN];
   assign clr_held = clr_lvl |
      (loc_lvl & cur_ff.ctrl[`RCT_C_LOCEN]); // RULE8
   assign do_clear = clr_held & ~cur_ff.qual_done & tick &
      (cur_ff.qual == QUAL_LIM); // RULE5
   assign cyc_inc = cur_ff.cyc + 1'b1;
   assign tgt_eff = (cur_ff.target == '0) ? `RCT_CW'(1) : cur_ff.target;
   assign wctrl = i_wdata[6:0];

   // next state
   always_comb begin
      nxt_t = cur_ff;
      // write-one clear first, so events later in this cycle win
      if (i_wr && i_addr == `RCT_A_ISTAT) begin
         nxt_t.istat = cur_ff.istat & ~i_wdata[3:0];
      end
      // one second divider
      nxt_t.div = tick ? '0 : cur_ff.div + 1'b1; // RULE15

      // clear qualification: held for the full time, once per hold
      if (!clr_held) begin
         nxt_t.qual = '0;
         nxt_t.qual_done = 1'b0;
      end else if (tick && !cur_ff.qual_done) begin
         if (cur_ff.qual == QUAL_LIM) begin
            nxt_t.qual_done = 1'b1; // RULE5
         end else begin
            nxt_t.qual = cur_ff.qual + 1'b1; // RULE15
         end
      end
      nxt_t.rst_ind = clr_held & ~cur_ff.qual_done; // RULE5

      // sequencer
      unique case (cur_ff.st)
         rct_pkg::ST_READY, rct_pkg::ST_PAUSE: begin
            if (start_p && timer_fn) begin
               if (cur_ff.set_time == '0) begin
                  nxt_t.istat[`RCT_I_REFUSE] = 1'b1; // RULE9
               end else begin
                  nxt_t.div = '0;
                  nxt_t.st = (cur_ff.st == rct_pkg::ST_PAUSE &&
                     cur_ff.resume_dly) ? rct_pkg::ST_DELAY
                     : rct_pkg::ST_RUN; // RULE1 RULE7 RULE13
               end
            end
         end
         rct_pkg::ST_RUN: begin
            if (stop_p) begin
               nxt_t.st = rct_pkg::ST_PAUSE; // RULE13
               nxt_t.resume_dly = 1'b0;
            end else if (tick) begin
               if (cur_ff.run_el + 1'b1 >= cur_ff.set_time) begin
                  nxt_t.run_el = '0;
                  nxt_t.cyc = cyc_inc; // RULE6
                  nxt_t.istat[`RCT_I_CYCLE] = 1'b1;
                  if (!cur_ff.ctrl[`RCT_C_REPEAT] || cyc_inc >= tgt_eff)
                  begin
                     nxt_t.st = rct_pkg::ST_DONE; // RULE4
                     nxt_t.istat[`RCT_I_DONE] = 1'b1;
                  end else if (cur_ff.delay == '0) begin
                     nxt_t.st = rct_pkg::ST_RUN; // RULE3
                  end else begin
                     nxt_t.st = rct_pkg::ST_DELAY; // RULE2
                  end
               end else begin
                  nxt_t.run_el = cur_ff.run_el + 1'b1; // RULE1
               end
            end
         end
         rct_pkg::ST_DELAY: begin
            if (stop_p) begin
               nxt_t.st = rct_pkg::ST_PAUSE; // RULE13
               nxt_t.resume_dly = 1'b1;
            end else if (tick) begin
               if (cur_ff.dly_el + 1'b1 >= cur_ff.delay) begin
                  nxt_t.dly_el = '0;
                  nxt_t.st = rct_pkg::ST_RUN; // RULE3
               end else begin
                  nxt_t.dly_el = cur_ff.dly_el + 1'b1; // RULE2
               end
            end
         end
         rct_pkg::ST_DONE, rct_pkg::ST_HALT: begin
            // start ignored here until a qualified clear
         end
      endcase

      // power return: pause keeps outputs off, otherwise stop safe
      if (i_power_restore && (cur_ff.st == rct_pkg::ST_RUN ||
         cur_ff.st == rct_pkg::ST_DELAY)) begin
         nxt_t.resume_dly = (cur_ff.st == rct_pkg::ST_DELAY);
         nxt_t.st = cur_ff.ctrl[`RCT_C_PAUSE] ? rct_pkg::ST_PAUSE
            : rct_pkg::ST_HALT; // RULE7
      end

      // register writes; settings need the code to have matched
      if (i_wr) begin
         unique case (i_addr)
            `RCT_A_CODE: nxt_t.unlocked =
               (i_wdata[15:0] == cur_ff.code); // RULE11
            `RCT_A_IMASK: nxt_t.imask = i_wdata[3:0];
            default: begin
            end
         endcase
         if (cur_ff.unlocked) begin
            unique case (i_addr)
               `RCT_A_CTRL: begin
                  nxt_t.ctrl = wctrl;
                  if (((wctrl ^ cur_ff.ctrl) & `RCT_CTRL_SAFE) != '0)
                  begin
                     nxt_t.st = rct_pkg::ST_HALT; // RULE14
                     nxt_t.istat[`RCT_I_FSAFE] = 1'b1;
                  end
               end
               `RCT_A_SET: nxt_t.set_time = i_wdata[`RCT_TW-1:0];
               `RCT_A_DLY: nxt_t.delay = i_wdata[`RCT_TW-1:0];
               `RCT_A_TGT: begin
                  nxt_t.target = i_wdata[`RCT_CW-1:0];
                  if (i_wdata[`RCT_CW-1:0] != cur_ff.target) begin
                     nxt_t.st = rct_pkg::ST_HALT; // RULE14
                     nxt_t.istat[`RCT_I_FSAFE] = 1'b1;
                  end
               end
               `RCT_A_NCODE: nxt_t.code = i_wdata[15:0];
               default: begin
               end
            endcase
         end
      end

      // events that arrived this cycle win over a write-one clear
      if (nxt_t.st == rct_pkg::ST_HALT && cur_ff.st != rct_pkg::ST_HALT)
      begin
         nxt_t.istat[`RCT_I_FSAFE] = 1'b1;
      end

      // qualified clear, or clock function selected, returns to ready
      if (do_clear || !nxt_t.ctrl[`RCT_C_FUNC]) begin
         nxt_t.st = rct_pkg::ST_READY; // RULE5 RULE8 RULE12
         nxt_t.run_el = '0;
         nxt_t.dly_el = '0;
         nxt_t.cyc = '0;
         nxt_t.resume_dly = 1'b0;
      end

      // outputs, each gated by its enable and the timer function
      nxt_t.op1 = (nxt_t.st == rct_pkg::ST_RUN) &
         nxt_t.ctrl[`RCT_C_OP1EN] & nxt_t.ctrl[`RCT_C_FUNC]; // RULE10
      nxt_t.op2 = (nxt_t.st == rct_pkg::ST_DONE) &
         nxt_t.ctrl[`RCT_C_OP2EN] & nxt_t.ctrl[`RCT_C_FUNC]; // RULE10
      nxt_t.irq = |(nxt_t.istat & nxt_t.imask);

      // displays follow the selected direction
      nxt_t.tdisp = nxt_t.ctrl[`RCT_C_DOWN] ?
         nxt_t.set_time - nxt_t.run_el : nxt_t.run_el; // RULE6
      nxt_t.ddisp = nxt_t.ctrl[`RCT_C_DOWN] ?
         nxt_t.delay - nxt_t.dly_el : nxt_t.dly_el; // RULE6

      // read data, valid only in the cycle after the strobe
      nxt_t.rdata = '0;
      if (i_rd) begin
         unique case (i_addr)
            `RCT_A_CTRL: nxt_t.rdata = {25'h000_0000, cur_ff.ctrl};
            `RCT_A_SET: nxt_t.rdata = {12'h000, cur_ff.set_time};
            `RCT_A_DLY: nxt_t.rdata = {12'h000, cur_ff.delay};
            `RCT_A_TGT: nxt_t.rdata = {24'h00_0000, cur_ff.target};
            `RCT_A_STAT: nxt_t.rdata = {15'h0000, cur_ff.unlocked,
               cur_ff.cyc, 1'b0, cur_ff.resume_dly, cur_ff.st};
            `RCT_A_TIME: nxt_t.rdata = {12'h000, cur_ff.tdisp};
            `RCT_A_DDISP: nxt_t.rdata = {12'h000, cur_ff.ddisp};
            `RCT_A_ISTAT: nxt_t.rdata = {28'h000_0000, cur_ff.istat};
            `RCT_A_IMASK: nxt_t.rdata = {28'h000_0000, cur_ff.imask};
            default: nxt_t.rdata = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         cur_ff <= '0;
         cur_ff.st <= rct_pkg::ST_READY;
         cur_ff.ctrl <= `RCT_CTRL_RST;
         cur_ff.set_time <= `RCT_SET_RST;
         cur_ff.delay <= `RCT_DLY_RST;
         cur_ff.target <= `RCT_TGT_RST;
         cur_ff.code <= `RCT_CODE_RST;
      end else begin
         cur_ff <= nxt_t;
      end
   end

   // outputs straight from the state register
   assign o_rdata = cur_ff.rdata;
   assign o_primary_ctl = cur_ff.op1;
   assign o_secondary_ctl = cur_ff.op2;
   assign o_clear_ind = cur_ff.rst_ind;
   assign o_irq = cur_ff.irq;
   assign o_time_disp = cur_ff.tdisp;
   assign o_delay_disp = cur_ff.ddisp;
   assign o_cycle_cnt = cur_ff.cyc;
endmodule : rct_timer

// File: test/rct_contacts.sv
/*
 * contact model: start, stop, clear and local buttons, with bounce.
 * assumes the timer samples the raw levels on i_sys_clk.
 */
module rct_contacts (
   input wire logic i_sys_clk, // clock
   output logic [3:0] o_raw // start, stop, clear, local
);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_raw = 4'h0;

   // chatter shorter than the filter, then a steady closure
   task automatic press(input int idx, input int hold);
      for (int k = 0; k < 6; k++) begin
         @(posedge i_sys_clk);
         o_raw[idx] <= k[0];
      end
      repeat (hold) @(posedge i_sys_clk);
      o_raw[idx] <= 1'b0;
   endtask : press
endmodule : rct_contacts

// File: test/rct_timer_monitor.sv
/*
 * port checker of rct_timer, bound into every instance.
 * assumes tick and filter counts follow the timer's parameters.
 */
`include "rct_defs.svh"
module rct_timer_monitor #(
   parameter int TICK_CYC = 20,
   parameter int DB_CYC = 4
) (
   input wire logic i_sys_clk, // clock
   input wire logic i_rst, // reset
   input wire logic i_clear_contact, // raw clear
   input wire logic i_local_clear, // raw local clear
   input wire logic i_power_restore, // power pulse
   input wire logic [7:0] i_addr, // address
   input wire logic i_wr, // write
   input wire logic i_rd, // read
   input wire logic [31:0] o_rdata, // read data
   input wire logic o_primary_ctl, // output one
   input wire logic o_secondary_ctl, // output two
   input wire logic o_clear_ind, // clear lamp
   input wire logic [`RCT_TW-1:0] o_time_disp, // time
   input wire logic [`RCT_CW-1:0] o_cycle_cnt // cycles
);
   int clr_run; // length of latest clear closure
   int clr_age; // clocks since clear last closed
   int quiet; // clocks since time display moved
   logic clr_any; // either clear contact closed

   assign clr_any = i_clear_contact | i_local_clear;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   // history of the clear contact and the display
   always_ff @(posedge i_sys_clk) begin
      clr_run <= clr_any ? ($past(clr_any) ? clr_run + 1 : 1) : clr_run;
      clr_age <= clr_any ? 0 : clr_age + 1;
      quiet <= $changed(o_time_disp) ? 0 : quiet + 1;
   end

   a_reset_quiet: assert property ($fell(i_rst) |->
      !o_primary_ctl && !o_secondary_ctl && o_cycle_cnt == 0)
      else $error("outputs after reset");
   a_outputs_apart: assert property (
      !(o_primary_ctl && o_secondary_ctl)) else $error("both outputs");
   a_done_holds: assert property (
      $fell(o_secondary_ctl) |-> $past(i_rst) || $past(i_wr) ||
      $past(i_wr, 2) || (clr_run >= 3 * TICK_CYC && clr_age < DB_CYC + 8))
      else $error("done dropped early");
   a_lamp_on_hold: assert property (
      o_clear_ind |-> clr_age < DB_CYC + 8) else $error("lamp unheld");
   a_code_hidden: assert property (
      $past(i_rd) && $past(i_addr) == `RCT_A_CODE |-> o_rdata == 32'h0)
      else $error("code readable");
   a_cycles_up: assert property (
      $changed(o_cycle_cnt) |-> o_cycle_cnt == 8'($past(o_cycle_cnt) + 1)
      || o_cycle_cnt == 0) else $error("cycles not up");
   a_tick_steps: assert property (
      $changed(o_time_disp) && o_primary_ctl && $past(o_primary_ctl) |->
      quiet >= TICK_CYC - 1) else $error("display too fast");
   a_power_pause: assert property (
      i_power_restore && o_primary_ctl |-> ##2 !o_primary_ctl [*4])
      else $error("output after power");
   a_done_counted: assert property (
      $rose(o_secondary_ctl) |-> o_cycle_cnt != 0 && !o_primary_ctl)
      else $error("done uncounted");
   c_done: cover property ($rose(o_secondary_ctl));
   c_cleared: cover property ($fell(o_secondary_ctl));
   c_lamp: cover property (o_clear_ind);
   c_power: cover property (i_power_restore && o_primary_ctl);
endmodule : rct_timer_monitor

bind rct_timer rct_timer_monitor #(.TICK_CYC(TICK_CYC), .DB_CYC(DB_CYC))
   u_mon (.i_sys_clk, .i_rst, .i_clear_contact, .i_local_clear,
   .i_power_restore, .i_addr, .i_wr, .i_rd, .o_rdata, .o_primary_ctl,
   .o_secondary_ctl, .o_clear_ind, .o_time_disp, .o_cycle_cnt);

// File: test/testbench.sv
/*
 * bench of rct_timer: register tasks, contact model, period model.
 * assumes short tick and filter counts for a quick run.
 */
`include "rct_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 20; // clocks per tick
   localparam int SET_S = 2, DLY_S = 1, TGT = 2; // sequence model
   logic i_sys_clk, i_rst, i_power_restore, i_wr, i_rd;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata, v;
   logic o_primary_ctl, o_secondary_ctl, o_clear_ind, o_irq;
   logic [`RCT_TW-1:0] o_time_disp, o_delay_disp;
   logic [`RCT_CW-1:0] o_cycle_cnt;
   logic [3:0] raw;
   int miscompares, comparisons, seed, hi_len;
   int widths[$]; // on period lengths seen

   rct_contacts u_sw (.i_sys_clk(i_sys_clk), .o_raw(raw));
   rct_timer #(.TICK_CYC(TK), .DB_CYC(4)) DUT (.i_sys_clk, .i_rst,
      .i_start_contact(raw[0]), .i_stop_contact(raw[1]),
      .i_clear_contact(raw[2]), .i_local_clear(raw[3]), .i_power_restore,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_primary_ctl,
      .o_secondary_ctl, .o_clear_ind, .o_irq, .o_time_disp, .o_delay_disp,
      .o_cycle_cnt);

   // clock
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   // length of each on period of output one
   always @(posedge i_sys_clk) begin
      if (o_primary_ctl) hi_len <= hi_len + 1;
      else if (hi_len != 0) begin
         widths.push_back(hi_len);
         hi_len <= 0;
      end
   end

   task automatic conclude();
      if (miscompares == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask : rd

   task automatic st(input logic [5:0] e);
      rd(`RCT_A_STAT);
      chk("state", v[5:0], e);
   endtask : st

   task automatic settle();
      repeat (2) @(posedge i_sys_clk);
      #1;
   endtask : settle

   // bounded wait for output one (s=0) or two (s=1) to reach lv
   task automatic wait_lvl(input int s, input logic lv);
      for (int k = 0; k < 400; k++) begin
         @(posedge i_sys_clk);
         #1;
         if ((s ? o_secondary_ctl : o_primary_ctl) === lv) return;
      end
      miscompares++;
      conclude();
   endtask : wait_lvl

   initial begin
      seed = 14114;
      i_rst = 1'b1;
      i_power_restore = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      // reset values, lock and code entry
      rd(`RCT_A_CTRL);
      chk("ctrl", v, 32'h0000_0007);
      rd(`RCT_A_TGT);
      chk("target", v, 32'h0000_0001);
      wr(`RCT_A_SET, 32'h0000_0002);
      rd(`RCT_A_SET);
      chk("locked set", v, 32'h0);
      wr(`RCT_A_CODE, ($random(seed) & 32'h0000_FFFF) | 32'h0000_0001);
      rd(`RCT_A_STAT);
      chk("bad code", v[16], 1'b0);
      wr(`RCT_A_CODE, 32'h0);
      rd(`RCT_A_STAT);
      chk("code ok", v[16], 1'b1);
      rd(`RCT_A_CODE);
      chk("code hidden", v, 32'h0);
      // zero set time refused, interrupt masked, raised, cleared
      u_sw.press(0, 12);
      st(rct_pkg::ST_READY);
      rd(`RCT_A_ISTAT);
      chk("refuse", v[2], 1'b1);
      chk("masked", o_irq, 1'b0);
      wr(`RCT_A_IMASK, 32'h0000_0004);
      settle();
      chk("irq", o_irq, 1'b1);
      wr(`RCT_A_ISTAT, 32'h0000_0004);
      settle();
      chk("irq clr", o_irq, 1'b0);
      // run with outputs disabled, then a target change halts
      wr(`RCT_A_SET, SET_S);
      wr(`RCT_A_DLY, DLY_S);
      u_sw.press(0, 12);
      st(rct_pkg::ST_RUN);
      chk("op1 off", o_primary_ctl, 1'b0);
      wr(`RCT_A_TGT, TGT);
      st(rct_pkg::ST_HALT);
      wr(`RCT_A_CTRL, 32'h0000_005F);
      u_sw.press(0, 12);
      st(rct_pkg::ST_HALT);
      u_sw.press(2, 5 * TK);
      settle();
      st(rct_pkg::ST_READY);
      // full repeated sequence
      u_sw.press(0, 12);
      wait_lvl(0, 1'b1);
      wait_lvl(0, 1'b0);
      chk("delay", o_delay_disp, DLY_S);
      chk("cycles", o_cycle_cnt, 1);
      wait_lvl(1, 1'b1);
      chk("cycles", o_cycle_cnt, TGT);
      chk("op1", o_primary_ctl, 1'b0);
      rd(`RCT_A_ISTAT);
      chk("events", v[1:0], 2'h3);
      chk("periods", widths.size(), TGT);
      foreach (widths[i]) chk("on time", widths[i], SET_S * TK);
      u_sw.press(0, 12);
      st(rct_pkg::ST_DONE);
      u_sw.press(3, 4 * TK);
      chk("local", o_secondary_ctl, 1'b1);
      fork
         u_sw.press(2, TK);
      join_none
      repeat (15) @(posedge i_sys_clk);
      #1 chk("lamp", o_clear_ind, 1'b1);
      repeat (TK) @(posedge i_sys_clk);
      #1 chk("short", o_secondary_ctl, 1'b1);
      u_sw.press(2, 5 * TK);
      settle();
      chk("cleared", o_secondary_ctl, 1'b0);
      chk("zeroed", o_cycle_cnt, 0);
      // stop, resume, power return, clock function
      u_sw.press(0, 12);
      u_sw.press(1, 12);
      chk("stop", o_primary_ctl, 1'b0);
      chk("tdisp", o_time_disp, SET_S);
      v = o_time_disp;
      repeat (3 * TK) @(posedge i_sys_clk);
      chk("frozen", o_time_disp, v);
      st(rct_pkg::ST_PAUSE);
      u_sw.press(0, 12);
      chk("resume", o_primary_ctl, 1'b1);
      i_power_restore <= 1'b1;
      @(posedge i_sys_clk);
      i_power_restore <= 1'b0;
      settle();
      chk("power", o_primary_ctl, 1'b0);
      st(rct_pkg::ST_PAUSE);
      u_sw.press(0, 12);
      chk("restart", o_primary_ctl, 1'b1);
      wr(`RCT_A_CTRL, 32'h0000_005E);
      settle();
      chk("clock fn", o_primary_ctl, 1'b0);
      // count up, cleared by the enabled local buttons
      wr(`RCT_A_CTRL, 32'h0000_007D);
      st(rct_pkg::ST_HALT);
      u_sw.press(3, 5 * TK);
      settle();
      st(rct_pkg::ST_READY);
      u_sw.press(0, 12);
      repeat (TK) @(posedge i_sys_clk);
      #1 chk("up time", o_time_disp, 1);
      conclude();
   end
endmodule : testbench
